// file: cid_pkg.sv
/*
 Constants, types and helpers for the caller-ID ring qualifier and power control.
 Assumes a 25 MHz system clock and an oscillator pin sampled in that domain.
*/
package cid_pkg;
   // Clock and oscillator figures
   localparam int CLK_HZ    = 25_000_000;
   localparam int XTAL_HZ   = 3_579_000;
   localparam int RES_HZ    = 455_000;
   localparam int INT_UP_HZ = 800;
   localparam int INT_DN_HZ = 400;
   localparam int XTAL_UP_DIV = XTAL_HZ / INT_UP_HZ;
   localparam int RES_UP_DIV  = RES_HZ / INT_UP_HZ;
   localparam int DN_PER_UP   = INT_UP_HZ / INT_DN_HZ;
   localparam int DIV_W       = 16;

   // Ring integrator
   localparam int INT_W = 6;
   localparam logic [INT_W-1:0] INT_MAX  = 6'h3f;
   localparam logic [INT_W-1:0] QUAL_ON  = 6'h30;
   localparam logic [INT_W-1:0] QUAL_OFF = 6'h20;

   // Tone decoding
   localparam int MARK_HZ     = 1200;
   localparam int SPACE_HZ    = 2200;
   localparam int BAUD        = 1200;
   localparam int TONE_MIN_HZ = 900;
   localparam int TONE_MAX_HZ = 2700;
   localparam int PER_W       = 16;
   localparam logic [PER_W-1:0] PER_SPLIT = PER_W'(CLK_HZ / ((MARK_HZ + SPACE_HZ) / 2));
   localparam logic [PER_W-1:0] PER_MIN   = PER_W'(CLK_HZ / TONE_MAX_HZ);
   localparam logic [PER_W-1:0] PER_MAX   = PER_W'(CLK_HZ / TONE_MIN_HZ);
   localparam logic [PER_W-1:0] PER_SAT   = 16'hffff;

   // Carrier hold and preamble rejection
   localparam int CNT_W            = 24;
   localparam int CARRIER_HOLD_MS  = 8;
   localparam int CARRIER_HOLD_DEF = (CARRIER_HOLD_MS * CLK_HZ + 999) / 1000;
   localparam int MARK_QUAL_BITS   = 60;
   localparam int MARK_QUAL_DEF    = (MARK_QUAL_BITS * CLK_HZ + BAUD - 1) / BAUD;
   localparam int FIFO_DEPTH       = 4;

   // Pin indices and idle levels
   localparam int PIN_FSEL = 0;
   localparam int PIN_RT   = 1;
   localparam int PIN_POR  = 2;
   localparam int PIN_NRG  = 3;
   localparam int PIN_LVL  = 4;
   localparam int PIN_OSC  = 5;
   localparam int PIN_FSK  = 6;
   localparam int NPINS    = 7;
   localparam logic [NPINS-1:0] PIN_IDLE = 7'h06;

   typedef enum logic [1:0] {PWR_STANDBY, PWR_RING, PWR_FULL} cid_pwr_e;

   typedef struct packed {
      logic mark;
      logic tone_ok;
   } cid_tone_s;

   // Power mode from the ring timer and power request levels
   function automatic cid_pwr_e cid_pwr_decode(input logic rt, input logic por_n);
      if (!por_n)
         return PWR_FULL;
      else if (!rt)
         return PWR_RING;
      else
         return PWR_STANDBY;
   endfunction : cid_pwr_decode
endpackage : cid_pkg

// file: cid_ring_power.sv
/*
 Ring qualification, staged power control, tone decoding, carrier detect
 and data output gating, with a small tone FIFO in the data path.
 Assumes all pins are asynchronous to sys_clk and that the pads resolve
 the open-drain outputs from the enables.
*/
`timescale 1ns/1ps

module cid_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             srst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      fill;
   logic             push;
   logic             pop;

   // Handshakes and flags
   assign in_ready  = (fill != (AW+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   // Storage
   always_ff @(posedge sys_clk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Pointers and fill level
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : cid_fifo

module cid_ring_power
   import cid_pkg::*;
#(
   parameter int XTAL_DIV     = XTAL_UP_DIV,
   parameter int CARRIER_HOLD = CARRIER_HOLD_DEF,
   parameter int MARK_QUAL    = MARK_QUAL_DEF
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic srst,
   // Pins from the line side and host
   input  wire logic clock_freq_select,
   input  wire logic oscillator_input,
   input  wire logic ring_timer_in,
   input  wire logic power_on_request_n,
   input  wire logic ring_energy_in,
   input  wire logic ring_level_in,
   input  wire logic fsk_line_in,
   // Open-drain detect outputs
   output logic      ring_valid_n_out,
   output logic      ring_valid_n_oe_n,
   output logic      carrier_valid_n_out,
   output logic      carrier_valid_n_oe_n,
   // Data outputs
   output logic      raw_data_out,
   output logic      validated_data_out,
   // Power state
   output cid_pwr_e  power_mode,
   output logic      osc_enable,
   output logic      wake_detect
);
   logic [NPINS-1:0] pins, filt;
   logic             osc_d, fsk_d, fsel_d;
   logic             osc_rise, fsk_rise, fsel_chg;
   logic [DIV_W-1:0] div_cnt, div_lim;
   logic [1:0]       dn_cnt;
   logic             tick_up, tick_dn;
   logic [INT_W-1:0] integ;
   logic             ring_q, next_ring_q;
   logic [PER_W-1:0] per_cnt;
   cid_tone_s        tone_in, tone_out;
   logic             tone_valid, tone_ready, tone_pop, in_ready;
   logic             carrier, next_carrier;
   logic             bit_q, next_bit;
   logic [CNT_W-1:0] hold_cnt, next_hold, mark_cnt;
   logic             valid_q, next_valid;
   logic             full_on;

   assign pins = {fsk_line_in, oscillator_input, ring_level_in, ring_energy_in,
                  power_on_request_n, ring_timer_in, clock_freq_select};

   // Three-stage synchronisers, change accepted when stages two and three agree
   for (genvar g = 0; g < NPINS; g++) begin : g_sync
      logic [2:0] sync;
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            sync    <= {3{PIN_IDLE[g]}};
            filt[g] <= PIN_IDLE[g];
         end else begin
            sync <= {sync[1:0], pins[g]};
            if (sync[1] == sync[2])
               filt[g] <= sync[2];
         end
      end
   end

   // Power mode and wake indication
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         power_mode  <= PWR_STANDBY;
         osc_enable  <= 1'b0;
         wake_detect <= 1'b0;
      end else begin
         power_mode  <= cid_pwr_decode(filt[PIN_RT], filt[PIN_POR]);
         osc_enable  <= filt[PIN_NRG] || !filt[PIN_RT] || !filt[PIN_POR];
         wake_detect <= filt[PIN_NRG];
      end
   end

   assign full_on = (power_mode == PWR_FULL);

   // Edge history of oscillator and tone line
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         osc_d  <= 1'b0;
         fsk_d  <= 1'b0;
         fsel_d <= PIN_IDLE[PIN_FSEL];
      end else begin
         osc_d  <= filt[PIN_OSC];
         fsk_d  <= filt[PIN_FSK];
         fsel_d <= filt[PIN_FSEL];
      end
   end

   assign osc_rise = filt[PIN_OSC] && !osc_d;
   assign fsk_rise = filt[PIN_FSK] && !fsk_d;
   assign div_lim  = filt[PIN_FSEL] ? DIV_W'(XTAL_DIV) : DIV_W'(RES_UP_DIV);
   assign fsel_chg = (filt[PIN_FSEL] != fsel_d);
   assign tick_up  = osc_rise && !fsel_chg && (div_cnt >= div_lim - 1'b1);
   assign tick_dn  = tick_up && (dn_cnt == 2'(DN_PER_UP - 1));

   // Oscillator divider, restarted when the select changes so no stale count ticks early
   always_ff @(posedge sys_clk) begin
      if (srst || power_mode == PWR_STANDBY || fsel_chg) begin
         div_cnt <= '0;
         dn_cnt  <= '0;
      end else if (osc_rise) begin
         div_cnt <= tick_up ? '0 : div_cnt + 1'b1;
         if (tick_up)
            dn_cnt <= tick_dn ? '0 : dn_cnt + 1'b1;
      end
   end

   // Ring integrator, cleared in standby
   always_ff @(posedge sys_clk) begin
      if (srst || power_mode == PWR_STANDBY) begin
         integ <= '0;
      end else if (filt[PIN_LVL]) begin
         if (tick_up && integ != INT_MAX)
            integ <= integ + 1'b1;
      end else if (tick_dn && integ != '0) begin
         integ <= integ - 1'b1;
      end
   end

   // Qualification with hysteresis
   always_comb begin
      next_ring_q = ring_q;
      if (power_mode == PWR_STANDBY)
         next_ring_q = 1'b0;
      else if (integ >= QUAL_ON)
         next_ring_q = 1'b1;
      else if (integ <= QUAL_OFF)
         next_ring_q = 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ring_q            <= 1'b0;
         ring_valid_n_out  <= 1'b0;
         ring_valid_n_oe_n <= 1'b1;
      end else begin
         ring_q            <= next_ring_q;
         ring_valid_n_oe_n <= !next_ring_q;
      end
   end

   // Tone period measurement, demodulator runs in full power only
   always_ff @(posedge sys_clk) begin
      if (srst || !full_on)
         per_cnt <= '0;
      else if (fsk_rise)
         per_cnt <= '0;
      else if (per_cnt != PER_SAT)
         per_cnt <= per_cnt + 1'b1;
   end

   assign tone_in.mark    = (per_cnt > PER_SPLIT);
   assign tone_in.tone_ok = (per_cnt >= PER_MIN) && (per_cnt <= PER_MAX);
   assign tone_valid      = fsk_rise && full_on;
   assign tone_ready      = full_on;

   cid_fifo #(
      .WIDTH ($bits(cid_tone_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_tone_fifo (
      .sys_clk   (sys_clk),
      .srst      (srst || !full_on), // Flushed outside full power
      .in_valid  (tone_valid && in_ready),
      .in_ready  (in_ready),
      .in_data   (tone_in),
      .out_valid (tone_pop),
      .out_ready (tone_ready),
      .out_data  (tone_out)
   );

   // Carrier hold, decoded bit and preamble rejection
   always_comb begin
      next_carrier = carrier;
      next_bit     = bit_q;
      next_hold    = hold_cnt;
      next_valid   = valid_q;
      if (!full_on) begin
         next_carrier = 1'b0;
         next_hold    = '0;
      end else if (tone_pop && tone_out.tone_ok) begin
         next_carrier = 1'b1;
         next_bit     = tone_out.mark;
         next_hold    = CNT_W'(CARRIER_HOLD);
      end else if (hold_cnt > CNT_W'(1)) begin
         next_hold = hold_cnt - 1'b1;
      end else begin
         next_hold    = '0;
         next_carrier = 1'b0;
      end
      if (!next_carrier)
         next_valid = 1'b0;
      else if (mark_cnt >= CNT_W'(MARK_QUAL))
         next_valid = 1'b1;
   end

   // Mark run counter, reset by any space before validation
   always_ff @(posedge sys_clk) begin
      if (srst || !carrier || !bit_q)
         mark_cnt <= '0;
      else if (mark_cnt != CNT_W'(MARK_QUAL))
         mark_cnt <= mark_cnt + 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         carrier              <= 1'b0;
         bit_q                <= 1'b1;
         hold_cnt             <= '0;
         valid_q              <= 1'b0;
         carrier_valid_n_out  <= 1'b0;
         carrier_valid_n_oe_n <= 1'b1;
         raw_data_out         <= 1'b1;
         validated_data_out   <= 1'b1;
      end else begin
         carrier              <= next_carrier;
         bit_q                <= next_bit;
         hold_cnt             <= next_hold;
         valid_q              <= next_valid;
         carrier_valid_n_oe_n <= !next_carrier;
         raw_data_out         <= next_carrier ? next_bit : 1'b1;
         validated_data_out   <= (next_carrier && next_valid) ? next_bit : 1'b1;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   logic [DIV_W-1:0] osc_seen;
   always_ff @(posedge sys_clk) begin
      if (srst || power_mode == PWR_STANDBY || fsel_chg || tick_up)
         osc_seen <= '0;
      else if (osc_rise)
         osc_seen <= osc_seen + 1'b1;
   end

   a_tick_rate: assert property (tick_up |->
      osc_seen == (filt[PIN_FSEL] ? DIV_W'(XTAL_DIV - 1) : DIV_W'(RES_UP_DIV - 1)))
      else $error("integrator tick spacing wrong");
   a_full_power: assert property (!filt[PIN_POR] |=> power_mode == PWR_FULL)
      else $error("power request low did not give full power");
   a_standby_mode: assert property (filt[PIN_POR] && filt[PIN_RT] |=>
      power_mode == PWR_STANDBY)
      else $error("standby not entered");
   a_partial_power: assert property (filt[PIN_POR] && !filt[PIN_RT] |=>
      power_mode == PWR_RING)
      else $error("partial power not entered");
   a_count_up: assert property (power_mode != PWR_STANDBY && filt[PIN_LVL] && tick_up
      && integ != INT_MAX |=> integ == $past(integ) + 1'b1)
      else $error("integrator did not count up");
   a_count_down: assert property (power_mode != PWR_STANDBY && !filt[PIN_LVL] && integ != '0
      |=> integ == $past(integ) - INT_W'($past(tick_dn)))
      else $error("integrator down count wrong");
   a_count_floor: assert property (integ == '0 && !filt[PIN_LVL] |=> integ == '0)
      else $error("integrator wrapped below zero");
   a_ring_qualify: assert property (integ >= QUAL_ON && power_mode != PWR_STANDBY
      |=> !ring_valid_n_oe_n)
      else $error("ring not qualified at threshold");
   a_ring_hold: assert property (ring_q && integ > QUAL_OFF && power_mode != PWR_STANDBY
      |=> ring_q && !ring_valid_n_oe_n)
      else $error("ring dropped above lower threshold");
   a_carrier_hold: assert property (carrier && full_on && hold_cnt > CNT_W'(1)
      |=> carrier && !carrier_valid_n_oe_n)
      else $error("carrier dropped inside hold time");
   a_raw_high: assert property (carrier_valid_n_oe_n |-> raw_data_out
      && validated_data_out)
      else $error("data output low without carrier");
   a_raw_follow: assert property (!carrier_valid_n_oe_n |-> raw_data_out == bit_q)
      else $error("raw data does not follow decoded bit");
   a_cooked_gate: assert property (!validated_data_out |-> valid_q && carrier
      && !bit_q)
      else $error("validated data low before validation");

   c_ring_qualified: cover property (ring_q ##1 power_mode == PWR_FULL);
   c_carrier_found:  cover property ($fell(carrier_valid_n_oe_n));
   c_validated:      cover property ($rose(valid_q));
   c_back_standby:   cover property (power_mode == PWR_FULL ##1 power_mode == PWR_STANDBY);
endmodule : cid_ring_power

// file: cid_host_model.sv
/*
 Behavioural host beside the caller-ID power controller: a driven clock
 on the oscillator pin and the power request pin.
 Assumes open-drain detect outputs on one wire with a pull-up.
*/
`timescale 1ns/1ps

module cid_host_model (
   // Clock
   input  wire logic sys_clk,
   // Commands from the bench
   input  wire logic auto_mode,
   input  wire logic request_cmd_n,
   // Detect enables from the device
   input  wire logic ring_valid_n_oe_n,
   input  wire logic carrier_valid_n_oe_n,
   // Pins to the device
   output logic      power_on_request_n,
   output logic      oscillator_input
);
   logic [2:0] osc_cnt = 3'h0;
   logic       wired_n;

   // Oscillator pin driven as a clock, four cycles per phase
   always @(posedge sys_clk) begin
      osc_cnt <= osc_cnt + 3'h1;
   end
   assign oscillator_input = osc_cnt[2];

   // Shared wire stays high unless a detect output pulls it low
   assign wired_n            = ring_valid_n_oe_n & carrier_valid_n_oe_n;
   assign power_on_request_n = auto_mode ? wired_n : request_cmd_n;
endmodule : cid_host_model

// file: test_cid_ring_power.sv
/*
 Self-checking bench for the ring qualifier and power control.
 Assumes the host model drives the oscillator and power request pins.
*/
`timescale 1ns/1ps

module test_cid_ring_power;
   import cid_pkg::*;
   localparam int MARK_P  = 20833;
   localparam int SPACE_P = 11364;
   localparam int LIMIT   = 90000;

   logic     sys_clk, srst, clock_freq_select, ring_timer_in;
   logic     ring_energy_in, ring_level_in, fsk_line_in, auto_mode, request_cmd_n;
   logic     power_on_request_n, oscillator_input, ring_oe_n, carrier_oe_n;
   logic     raw_data_out, validated_data_out, osc_enable, wake_detect;
   logic     ring_out, carrier_out;
   cid_pwr_e power_mode;
   int       failures, comparisons, cycles;

   // Shortened counts so the run stays brief
   cid_ring_power #(.XTAL_DIV(4), .CARRIER_HOLD(25000), .MARK_QUAL(5000)) dut (
      .sys_clk(sys_clk), .srst(srst), .clock_freq_select(clock_freq_select),
      .oscillator_input(oscillator_input), .ring_timer_in(ring_timer_in),
      .power_on_request_n(power_on_request_n), .ring_energy_in(ring_energy_in),
      .ring_level_in(ring_level_in), .fsk_line_in(fsk_line_in),
      .ring_valid_n_out(ring_out), .ring_valid_n_oe_n(ring_oe_n),
      .carrier_valid_n_out(carrier_out), .carrier_valid_n_oe_n(carrier_oe_n),
      .raw_data_out(raw_data_out), .validated_data_out(validated_data_out),
      .power_mode(power_mode), .osc_enable(osc_enable), .wake_detect(wake_detect));

   cid_host_model host (
      .sys_clk(sys_clk), .auto_mode(auto_mode), .request_cmd_n(request_cmd_n),
      .ring_valid_n_oe_n(ring_oe_n), .carrier_valid_n_oe_n(carrier_oe_n),
      .power_on_request_n(power_on_request_n), .oscillator_input(oscillator_input));

   // Clock
   always #20 sys_clk = ~sys_clk;

   // Hang guard
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles >= LIMIT) begin
         failures = failures + 1;
         end_of_test();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   // Outputs are read away from the launching edge
   task automatic settle;
      @(negedge sys_clk);
   endtask : settle

   task automatic chk_bit(input string name, input logic exp, input logic seen);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("Error %s expected %b seen %b", name, exp, seen);
      end
   endtask : chk_bit

   task automatic chk_mode(input cid_pwr_e exp, input cid_pwr_e seen);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("Error power_mode expected %0d seen %0d", exp, seen);
      end
   endtask : chk_mode

   // One tone rising edge a full period after the previous one
   task automatic fsk_rise(input int period);
      tick(period - 100);
      fsk_line_in <= 1'b1;
      tick(100);
      fsk_line_in <= 1'b0;
      settle();
   endtask : fsk_rise

   // Idle levels, then wake detection while still in standby
   task automatic scen_standby;
      settle();
      chk_mode(PWR_STANDBY, power_mode);
      chk_bit("ring_valid_n_oe_n", 1'b1, ring_oe_n);
      chk_bit("carrier_valid_n_oe_n", 1'b1, carrier_oe_n);
      chk_bit("raw_data_out", 1'b1, raw_data_out);
      chk_bit("validated_data_out", 1'b1, validated_data_out);
      chk_bit("osc_enable", 1'b0, osc_enable);
      tick(1);
      ring_energy_in <= 1'b1;
      tick(6);
      settle();
      chk_bit("wake_detect", 1'b1, wake_detect);
      chk_bit("osc_enable", 1'b1, osc_enable);
      chk_mode(PWR_STANDBY, power_mode);
      tick(1);
      ring_energy_in <= 1'b0;
   endtask : scen_standby

   // Slow resonator ticks, then fast crystal ticks, hysteresis and saturation
   task automatic scen_ring;
      clock_freq_select <= 1'b0;
      ring_timer_in     <= 1'b0;
      tick(6);
      settle();
      chk_mode(PWR_RING, power_mode);
      tick(1);
      ring_level_in <= 1'b1;
      tick(1700);
      settle();
      chk_bit("ring_valid_n_oe_n", 1'b1, ring_oe_n);
      tick(1);
      clock_freq_select <= 1'b1;
      tick(1440);
      settle();
      chk_bit("ring_valid_n_oe_n", 1'b1, ring_oe_n);
      tick(160);
      settle();
      chk_bit("ring_valid_n_oe_n", 1'b0, ring_oe_n);
      tick(700);
      settle();
      chk_bit("ring_valid_n_oe_n", 1'b0, ring_oe_n);
      tick(1);
      ring_level_in <= 1'b0;
      tick(1800);
      settle();
      chk_bit("ring_valid_n_oe_n", 1'b0, ring_oe_n);
      tick(330);
      settle();
      chk_bit("ring_valid_n_oe_n", 1'b1, ring_oe_n);
      tick(2200);
      settle();
      chk_bit("ring_valid_n_oe_n", 1'b1, ring_oe_n);
      tick(1);
      ring_timer_in <= 1'b1;
      tick(6);
      settle();
      chk_mode(PWR_STANDBY, power_mode);
   endtask : scen_ring

   // Ring output fed back to the power request, then the bench command holds it
   task automatic scen_auto;
      tick(1);
      ring_timer_in <= 1'b0;
      ring_level_in <= 1'b1;
      tick(1700);
      settle();
      chk_bit("ring_valid_n_oe_n", 1'b0, ring_oe_n);
      chk_bit("ring_valid_n_out", 1'b0, ring_out);
      chk_mode(PWR_FULL, power_mode);
      tick(1);
      ring_timer_in <= 1'b1;
      request_cmd_n <= 1'b0;
      auto_mode     <= 1'b0;
      tick(6);
      settle();
      chk_mode(PWR_FULL, power_mode);
   endtask : scen_auto

   // Space preamble, mark run, space data, then carrier hold expiry
   task automatic scen_fsk;
      fsk_rise(1000);
      chk_bit("carrier_valid_n_oe_n", 1'b1, carrier_oe_n);
      chk_bit("raw_data_out", 1'b1, raw_data_out);
      fsk_rise(SPACE_P);
      chk_bit("carrier_valid_n_oe_n", 1'b0, carrier_oe_n);
      chk_bit("carrier_valid_n_out", 1'b0, carrier_out);
      chk_bit("raw_data_out", 1'b0, raw_data_out);
      chk_bit("validated_data_out", 1'b1, validated_data_out);
      fsk_rise(MARK_P);
      chk_bit("carrier_valid_n_oe_n", 1'b0, carrier_oe_n);
      chk_bit("raw_data_out", 1'b1, raw_data_out);
      fsk_rise(SPACE_P);
      chk_bit("raw_data_out", 1'b0, raw_data_out);
      chk_bit("validated_data_out", 1'b0, validated_data_out);
      tick(23800);
      settle();
      chk_bit("carrier_valid_n_oe_n", 1'b0, carrier_oe_n);
      tick(1200);
      settle();
      chk_bit("carrier_valid_n_oe_n", 1'b1, carrier_oe_n);
      chk_bit("raw_data_out", 1'b1, raw_data_out);
      chk_bit("validated_data_out", 1'b1, validated_data_out);
   endtask : scen_fsk

   // Request released: back to standby with the integrator cleared
   task automatic scen_release;
      tick(1);
      request_cmd_n <= 1'b1;
      tick(6);
      settle();
      chk_mode(PWR_STANDBY, power_mode);
      chk_bit("ring_valid_n_oe_n", 1'b1, ring_oe_n);
      tick(1);
      ring_level_in <= 1'b0;
   endtask : scen_release

   task automatic end_of_test;
      if (failures == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      sys_clk           = 1'b0;
      srst              = 1'b1;
      clock_freq_select = 1'b1;
      ring_timer_in     = 1'b1;
      ring_energy_in    = 1'b0;
      ring_level_in     = 1'b0;
      fsk_line_in       = 1'b0;
      auto_mode         = 1'b1;
      request_cmd_n     = 1'b1;
      failures          = 0;
      comparisons       = 0;
      cycles            = 0;
      tick(4);
      srst <= 1'b0;
      tick(1);
      scen_standby();
      scen_ring();
      scen_auto();
      scen_fsk();
      scen_release();
      end_of_test();
   end
endmodule : test_cid_ring_power
